// File: include/flash_irq_pkg.sv
// shared constants and carrier types of the flash controller interrupt block
// assumes a 32-bit axi4-lite register bus and a single system clock
package flash_irq_pkg;

  // register byte offsets
  localparam logic [7:0] OFFSET_RAW_STATUS    = 8'h0C;
  localparam logic [7:0] OFFSET_MASK          = 8'h10;
  localparam logic [7:0] OFFSET_MASKED_STATUS = 8'h14;
  localparam logic [7:0] OFFSET_OP_CONTROL    = 8'h08;

  // field positions in the three interrupt registers
  localparam int BIT_ACCESS  = 0;
  localparam int BIT_PROGRAM = 1;
  // field positions in the operation control register
  localparam int BIT_OP_WRITE  = 0;
  localparam int BIT_OP_ERASE  = 1;
  localparam int BIT_OP_MERASE = 2;
  localparam int BIT_OP_COMMIT = 3;

  // write key that must accompany an operation request
  localparam logic [15:0] OP_WRITE_KEY = 16'hA442;

  // reset values
  localparam logic [1:0] RESET_IRQ_BITS = 2'h0;
  localparam logic [3:0] RESET_OP_BITS  = 4'h0;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // timing: clock period and longest operation times, in ns
  localparam longint CLK_PERIOD_NS   = 10;
  localparam longint WRITE_TIME_NS   = 50000;
  localparam longint ERASE_TIME_NS   = 25000000;
  localparam longint MERASE_TIME_NS  = 250000000;
  localparam longint COMMIT_TIME_NS  = 50000;
  localparam longint WRITE_CYCLES    = WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam longint ERASE_CYCLES    = ERASE_TIME_NS / CLK_PERIOD_NS;
  localparam longint MERASE_CYCLES   = MERASE_TIME_NS / CLK_PERIOD_NS;
  localparam longint COMMIT_CYCLES   = COMMIT_TIME_NS / CLK_PERIOD_NS;

  // write channel state of the slave
  typedef enum logic [1:0] {
    WR_IDLE,
    WR_RESP
  } wr_state_t;

  // pair of interrupt sources
  typedef struct packed {
    logic program_done;
    logic access_violation;
  } irq_pair_t;

  // event inputs from the flash array
  typedef struct packed {
    logic op_done;
    logic access_violation;
  } flash_event_t;

  // whole state of the block
  typedef struct packed {
    wr_state_t  wr_state;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [1:0]  raw;
    logic [1:0]  enable;
    logic [3:0]  op_busy;
    logic [31:0] op_count;
    logic        op_start;
  } state_t;

endpackage

// File: logic/flash_ctrl_irq_status.sv
// interrupt status, mask and clear of the flash controller, with the
// operation control bits that start write, erase, mass erase and commit operations
// assumes an axi4-lite master on clk and a flash array on the same clock
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
module flash_ctrl_irq_status #(
  parameter longint WRITE_CYCLES  = flash_irq_pkg::WRITE_CYCLES,
  parameter longint ERASE_CYCLES  = flash_irq_pkg::ERASE_CYCLES,
  parameter longint MERASE_CYCLES = flash_irq_pkg::MERASE_CYCLES,
  parameter longint COMMIT_CYCLES = flash_irq_pkg::COMMIT_CYCLES
) (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  // axi4-lite slave
  input  wire logic [7:0]                  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [7:0]                  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // flash array events, same clock domain
  input  wire flash_irq_pkg::flash_event_t flash_event,
  // operation running, one bit per control bit
  output logic [3:0]                       op_busy,
  // one-cycle start pulse for an operation
  output logic                             op_start,
  output logic                             irq
);

  initial begin
    if (WRITE_CYCLES < 1 || ERASE_CYCLES < 1 || MERASE_CYCLES < 1 ||
        COMMIT_CYCLES < 1 || MERASE_CYCLES > 64'hFFFFFFFF) begin
      $error("operation cycle counts out of range");
    end
  end

  flash_irq_pkg::state_t state;
  flash_irq_pkg::state_t next_state;

  logic       wr_fire;
  logic       rd_fire;
  logic [1:0] masked;
  logic [1:0] clear_bits;
  logic [1:0] new_events;
  logic       op_done_pulse;
  logic       timer_done;
  logic [31:0] start_count;
  logic [31:0] wr_word;

  // masked view feeds both the irq and the status read
  assign masked = state.raw & state.enable;
  assign irq    = |masked;

  // write address and data taken together, only when no response pending
  assign s_axi_awready = (state.wr_state == flash_irq_pkg::WR_IDLE) &&
                         s_axi_awvalid && s_axi_wvalid;
  assign s_axi_wready  = s_axi_awready;
  assign wr_fire       = s_axi_awready;
  assign s_axi_bvalid  = (state.wr_state == flash_irq_pkg::WR_RESP);
  assign s_axi_bresp   = state.bresp;

  assign s_axi_arready = !state.rvalid;
  assign rd_fire       = s_axi_arvalid && !state.rvalid;
  assign s_axi_rvalid  = state.rvalid;
  assign s_axi_rdata   = state.rdata;
  assign s_axi_rresp   = state.rresp;

  assign op_busy  = state.op_busy;
  assign op_start = state.op_start;

  // byte strobes applied lane by lane
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wr_word[8*i +: 8] = s_axi_wstrb[i] ? s_axi_wdata[8*i +: 8] : 8'h00;
    end
  end

  // the operation timer stands in for array completion while an operation is busy
  assign timer_done    = (state.op_busy != 4'h0) &&
                         (state.op_count == 32'h00000001);
  assign op_done_pulse = timer_done || (flash_event.op_done &&
                         (state.op_busy != 4'h0));

  // priority selection of the operation length, write bit first
  always_comb begin
    start_count = 32'h00000000;
    if (wr_word[flash_irq_pkg::BIT_OP_WRITE]) begin
      start_count = 32'(WRITE_CYCLES);
    end else if (wr_word[flash_irq_pkg::BIT_OP_ERASE]) begin
      start_count = 32'(ERASE_CYCLES);
    end else if (wr_word[flash_irq_pkg::BIT_OP_MERASE]) begin
      start_count = 32'(MERASE_CYCLES);
    end else if (wr_word[flash_irq_pkg::BIT_OP_COMMIT]) begin
      start_count = 32'(COMMIT_CYCLES);
    end
  end

  // clear requests: write one to the masked status register
  always_comb begin
    clear_bits = 2'h0;
    if (wr_fire &&
        s_axi_awaddr == flash_irq_pkg::OFFSET_MASKED_STATUS) begin
      clear_bits = wr_word[1:0];
    end
  end

  // raw events: programming finished or protection broken
  always_comb begin
    new_events = 2'h0;
    new_events[flash_irq_pkg::BIT_PROGRAM] = op_done_pulse &&
      (state.op_busy[flash_irq_pkg::BIT_OP_WRITE] ||
       state.op_busy[flash_irq_pkg::BIT_OP_ERASE]);
    new_events[flash_irq_pkg::BIT_ACCESS] =
      flash_event.access_violation;
  end

  // next state of the whole block
  always_comb begin
    next_state          = state;
    next_state.op_start = 1'b0;

    // set wins over a clear arriving in the same cycle
    next_state.raw = (state.raw & ~clear_bits) | new_events;

    // operation tracking, busy bit drops on completion
    if (state.op_busy != 4'h0) begin
      if (op_done_pulse) begin
        next_state.op_busy  = flash_irq_pkg::RESET_OP_BITS;
        next_state.op_count = 32'h00000000;
      end else begin
        next_state.op_count = state.op_count - 32'h00000001;
      end
    end

    // write channel
    case (state.wr_state)
      flash_irq_pkg::WR_IDLE: begin
        if (wr_fire) begin
          next_state.bresp    = flash_irq_pkg::RESP_OKAY;
          next_state.wr_state = flash_irq_pkg::WR_RESP;
          case (s_axi_awaddr)
            flash_irq_pkg::OFFSET_MASK: begin
              next_state.enable = wr_word[1:0];
            end
            flash_irq_pkg::OFFSET_OP_CONTROL: begin
              // without the key or while busy the request is dropped
              if (s_axi_wdata[31:16] == flash_irq_pkg::OP_WRITE_KEY &&
                  s_axi_wstrb[3:2] == 2'b11 &&
                  state.op_busy == 4'h0 && wr_word[3:0] != 4'h0) begin
                next_state.op_busy  = wr_word[3:0];
                next_state.op_count = start_count;
                next_state.op_start = 1'b1;
              end
            end
            flash_irq_pkg::OFFSET_RAW_STATUS,
            flash_irq_pkg::OFFSET_MASKED_STATUS: begin
              // read-only bits ignore writes; clears handled above
            end
            default: begin
              next_state.bresp = flash_irq_pkg::RESP_SLVERR;
            end
          endcase
        end
      end
      flash_irq_pkg::WR_RESP: begin
        if (s_axi_bready) begin
          next_state.wr_state = flash_irq_pkg::WR_IDLE;
        end
      end
      default: begin
        next_state.wr_state = flash_irq_pkg::WR_IDLE;
      end
    endcase

    // read channel, reserved bits read zero
    if (state.rvalid && s_axi_rready) begin
      next_state.rvalid = 1'b0;
    end
    if (rd_fire) begin
      next_state.rvalid = 1'b1;
      next_state.rresp  = flash_irq_pkg::RESP_OKAY;
      next_state.rdata  = 32'h00000000;
      case (s_axi_araddr)
        flash_irq_pkg::OFFSET_RAW_STATUS: begin
          next_state.rdata[1:0] = state.raw;
        end
        flash_irq_pkg::OFFSET_MASK: begin
          next_state.rdata[1:0] = state.enable;
        end
        flash_irq_pkg::OFFSET_MASKED_STATUS: begin
          next_state.rdata[1:0] = masked;
        end
        flash_irq_pkg::OFFSET_OP_CONTROL: begin
          next_state.rdata[3:0] = state.op_busy;
        end
        default: begin
          next_state.rresp = flash_irq_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // single register stage for all state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state          <= '0;
      state.wr_state <= flash_irq_pkg::WR_IDLE;
      state.raw      <= flash_irq_pkg::RESET_IRQ_BITS;
      state.enable   <= flash_irq_pkg::RESET_IRQ_BITS;
      state.op_busy  <= flash_irq_pkg::RESET_OP_BITS;
    end else begin
      state <= next_state;
    end
  end

endmodule

// File: bench/flash_irq_properties.sv
// port-level assertions of the flash interrupt block
// assumes one clock, sync reset and full-word register writes
`timescale 1ns/10ps
module flash_irq_props (
  input logic                        clk,
  input logic                        sys_rst,
  input logic [7:0]                  s_axi_awaddr,
  input logic                        s_axi_awvalid,
  input logic                        s_axi_awready,
  input logic [31:0]                 s_axi_wdata,
  input logic                        s_axi_bvalid,
  input logic                        s_axi_arvalid,
  input logic                        s_axi_arready,
  input logic                        s_axi_rvalid,
  input flash_irq_pkg::flash_event_t flash_event,
  input logic [3:0]                  op_busy,
  input logic                        op_start,
  input logic                        irq
);
  logic [1:0] en;
  wire        wr = s_axi_awvalid && s_axi_awready;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // enable shadow; strobes are assumed full, so no byte gating
  always_ff @(posedge clk) begin
    if (sys_rst)
      en <= 2'h0;
    else if (wr && s_axi_awaddr == 8'h10)
      en <= s_axi_wdata[1:0];
  end
  property p_off; en == 2'h0 |-> !irq; endproperty
  a_off: assert property (p_off) else $error("irq while disabled");
  property p_acc; flash_event.access_violation && en[0] |=> irq; endproperty
  a_acc: assert property (p_acc) else $error("violation lost");
  property p_hold; irq && !wr |=> irq; endproperty
  a_hold: assert property (p_hold) else $error("irq dropped");
  property p_done;
    (($fell(op_busy[0]) || $fell(op_busy[1])) && en[1]) |-> ##[0:1] irq;
  endproperty
  a_done: assert property (p_done) else $error("no done irq");
  property p_busy; op_start |-> ##[0:1] (op_busy != 4'h0); endproperty
  a_busy: assert property (p_busy) else $error("busy not shown");
  property p_pulse; op_start |=> !op_start; endproperty
  a_pulse: assert property (p_pulse) else $error("start too long");
  property p_b; wr |=> s_axi_bvalid; endproperty
  a_b: assert property (p_b) else $error("late write answer");
  property p_r; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r: assert property (p_r) else $error("late read answer");
endmodule
bind flash_ctrl_irq_status flash_irq_props i_props (.*);

// File: bench/flash_array_model.sv
// flash array stand-in: reports early ends and protection faults
// assumes the bench commands both; otherwise the block's timer ends ops
`timescale 1ns/10ps
module flash_array_model (
  input logic                         clk,
  input logic                         op_start,
  input logic                         early,
  input logic                         viol,
  output flash_irq_pkg::flash_event_t flash_event
);
  logic [9:0] dly = 10'h0;
  // early end ten cycles after start, shorter than any op timer
  always_ff @(posedge clk) begin
    dly <= {dly[8:0], op_start & early};
  end
  assign flash_event = '{op_done: dly[9], access_violation: viol};
endmodule

// File: bench/flash_ctrl_irq_status_test.sv
// self-checking bench of the flash interrupt block
// assumes the array model beside it and short op timers
`timescale 1ns/10ps
module flash_ctrl_irq_status_test;
  logic        clk = 1'h0, sys_rst = 1'h1, early = 1'h0, viol = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF, op_busy;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, op_start, irq;
  flash_irq_pkg::flash_event_t flash_event;
  int          errors = 0, cmp_count = 0, cycles = 0;
  flash_ctrl_irq_status #(20, 40, 20, 20) i_dut (.*);
  flash_array_model i_array (.*);
  always #5 clk = ~clk;
  // hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one write, valids held until taken, bready until bvalid
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] rsp);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do @(posedge clk); while (!s_axi_awready);
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid <= 1'h0;
    s_axi_bready <= 1'h1;
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk({30'h0, s_axi_bresp}, {30'h0, rsp});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    s_axi_rready <= 1'h1;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, exp);
    // unmapped offsets answer with a slave error
    if (a == flash_irq_pkg::OFFSET_OP_CONTROL ||
        a == flash_irq_pkg::OFFSET_RAW_STATUS ||
        a == flash_irq_pkg::OFFSET_MASK ||
        a == flash_irq_pkg::OFFSET_MASKED_STATUS)
      chk({30'h0, s_axi_rresp}, {30'h0, flash_irq_pkg::RESP_OKAY});
    else
      chk({30'h0, s_axi_rresp}, {30'h0, flash_irq_pkg::RESP_SLVERR});
  endtask
  task automatic t_regs;
    rd(8'h0C, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'h14, 32'h0);
    wr(8'h10, 32'hFFFFFFFF, 2'h0);
    rd(8'h10, 32'h3);
    wr(8'h0C, 32'h3, 2'h0);
    rd(8'h0C, 32'h0);
    wr(8'h40, 32'h3, 2'h2);
    rd(8'h40, 32'h0);
  endtask
  // fault with its enable off, then on, then cleared
  task automatic t_viol;
    wr(8'h10, 32'h0, 2'h0);
    viol <= 1'h1;
    @(posedge clk);
    viol <= 1'h0;
    rd(8'h0C, 32'h1);
    rd(8'h14, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(8'h10, 32'h1, 2'h0);
    chk({31'h0, irq}, 32'h1);
    rd(8'h14, 32'h1);
    wr(8'h14, 32'h2, 2'h0);
    rd(8'h0C, 32'h1);
    wr(8'h14, 32'h1, 2'h0);
    rd(8'h0C, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // fault while its enable is on reaches irq directly
    viol <= 1'h1;
    @(posedge clk);
    viol <= 1'h0;
    @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(8'h14, 32'h1, 2'h0);
    chk({31'h0, irq}, 32'h0);
  endtask
  // each operation kind; only write and erase count as programming
  task automatic t_ops;
    logic [31:0] pd;
    wr(8'h10, 32'h2, 2'h0);
    for (int i = 0; i < 4; i++) begin
      pd = (i < 2) ? 32'h2 : 32'h0;
      early <= (i == 1);
      wr(8'h08, 32'hA4420000 | (32'h1 << i), 2'h0);
      rd(8'h08, 32'h1 << i);
      do @(posedge clk); while (op_busy !== 4'h0);
      rd(8'h08, 32'h0);
      rd(8'h0C, pd);
      rd(8'h14, pd);
      chk({31'h0, irq}, pd >> 1);
      wr(8'h14, 32'h2, 2'h0);
      rd(8'h0C, 32'h0);
    end
  endtask
  task automatic summarize;
    $display("errors %0d of %0d compares", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    t_regs();
    t_viol();
    t_ops();
    summarize();
  end
endmodule
